/* inc/pin_routing_map.svh */
`ifndef PIN_ROUTING_MAP_SVH
`define PIN_ROUTING_MAP_SVH

// Register offsets on the control port.
`define SECONDARY_INPUT_ROUTING_ADDR     8'h12
`define MICROPHONE_INPUT_CONFIG_ADDR     8'h13
`define PIN_CONTROL_FUNCTIONS_ADDR       8'h14
`define BIAS_AND_CONVERT_PIN_SELECT_ADDR 8'h15

// Reset values.
`define SECONDARY_INPUT_ROUTING_RESET     8'h00
`define MICROPHONE_INPUT_CONFIG_RESET     8'h00
`define PIN_CONTROL_FUNCTIONS_RESET       8'h00
`define BIAS_AND_CONVERT_PIN_SELECT_RESET 8'h00

// Writable bits; the rest are reserved and read as zero.
`define SECONDARY_INPUT_ROUTING_MASK     8'hfc
`define MICROPHONE_INPUT_CONFIG_MASK     8'hff
`define PIN_CONTROL_FUNCTIONS_MASK       8'hff
`define BIAS_AND_CONVERT_PIN_SELECT_MASK 8'hf0
`define UNMAPPED_READ_VALUE              8'h00

// Secondary input routing fields.
`define AUX_PORT_IN_SOURCE_MSB     7
`define AUX_PORT_IN_SOURCE_LSB     5
`define AUX_PORT_IN_TWO_SOURCE_MSB 4
`define AUX_PORT_IN_TWO_SOURCE_LSB 2

// Microphone configuration fields.
`define REC_CH_ONE_TYPE_BIT     7
`define REC_CH_TWO_TYPE_BIT     6
`define MIC_PAIR_A_EDGE_BIT     5
`define MIC_PAIR_B_EDGE_BIT     4
`define MIC_PAIR_A_SOURCE_MSB   3
`define MIC_PAIR_A_SOURCE_LSB   2
`define MIC_PAIR_B_SOURCE_MSB   1
`define MIC_PAIR_B_SOURCE_LSB   0

// Pin control function fields.
`define MIC_SOURCE_OVERRIDE_BIT          7
`define SERIAL_OUT_WITH_IN_BIT           6
`define RECORD_CONV_POWERDOWN_PIN_MSB    5
`define RECORD_CONV_POWERDOWN_PIN_LSB    4
`define PLAYBACK_CONV_POWERDOWN_PIN_MSB  3
`define PLAYBACK_CONV_POWERDOWN_PIN_LSB  2
`define POWER_LIMIT_PIN_ENABLE_BIT       1
`define AUX_FUNCTION_PIN_ENABLE_BIT      0

// Bias and converter start fields.
`define BIAS_ENABLE_PIN_SELECT_MSB 7
`define BIAS_ENABLE_PIN_SELECT_LSB 6
`define AUX_CONVERT_START_PIN_MSB  5
`define AUX_CONVERT_START_PIN_LSB  4

// Serial out pin function codes.
`define SERIAL_OUT_DISABLED     4'h0
`define SERIAL_OUT_AS_INPUT     4'h1
`define SERIAL_OUT_PRIMARY_DATA 4'h5
`define SERIAL_OUT_RESERVED     4'hf

`endif

/* inc/pin_routing_pkg.sv */
package pin_routing_pkg;

   typedef enum logic [1:0]
   {
      PIN_NONE       = 2'b00,
      PIN_MULTI_ONE  = 2'b01,
      PIN_MULTI_TWO  = 2'b10,
      PIN_INPUT_ONLY = 2'b11
   } pin_source_type;

   typedef enum logic [2:0]
   {
      PORT_NONE       = 3'b000,
      PORT_MULTI_ONE  = 3'b001,
      PORT_MULTI_TWO  = 3'b010,
      PORT_INPUT_ONLY = 3'b011,
      PORT_SERIAL_OUT = 3'b100,
      PORT_PRIMARY_IN = 3'b101,
      PORT_SPARE_SIX  = 3'b110,
      PORT_SPARE_SEVEN = 3'b111
   } port_source_type;

endpackage

/* logic/routing_register_bank.sv */
`include "pin_routing_map.svh"

module routing_register_bank
   import pin_routing_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       resetn,
   input  wire logic       write_enable,
   input  wire logic [7:0] address,
   input  wire logic [7:0] write_data,
   output logic      [7:0] read_data,
   output logic      [7:0] secondary_input_routing,
   output logic      [7:0] microphone_input_config,
   output logic      [7:0] pin_control_functions,
   output logic      [7:0] bias_and_convert_pin_select
);

   logic [7:0] next_read_data;

   // Reserved bits are never stored, so they always read back as zero.
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         secondary_input_routing     <= `SECONDARY_INPUT_ROUTING_RESET;
         microphone_input_config     <= `MICROPHONE_INPUT_CONFIG_RESET;
         pin_control_functions       <= `PIN_CONTROL_FUNCTIONS_RESET;
         bias_and_convert_pin_select <= `BIAS_AND_CONVERT_PIN_SELECT_RESET;
      end
      else if (write_enable)
      begin
         unique case (address)
            `SECONDARY_INPUT_ROUTING_ADDR:
               secondary_input_routing <= write_data & `SECONDARY_INPUT_ROUTING_MASK;
            `MICROPHONE_INPUT_CONFIG_ADDR:
               microphone_input_config <= write_data & `MICROPHONE_INPUT_CONFIG_MASK;
            `PIN_CONTROL_FUNCTIONS_ADDR:
               pin_control_functions <= write_data & `PIN_CONTROL_FUNCTIONS_MASK;
            `BIAS_AND_CONVERT_PIN_SELECT_ADDR:
               bias_and_convert_pin_select <= write_data
                                              & `BIAS_AND_CONVERT_PIN_SELECT_MASK;
            default:
            begin
            end
         endcase
      end
   end

   always_comb
   begin
      unique case (address)
         `SECONDARY_INPUT_ROUTING_ADDR:     next_read_data = secondary_input_routing;
         `MICROPHONE_INPUT_CONFIG_ADDR:     next_read_data = microphone_input_config;
         `PIN_CONTROL_FUNCTIONS_ADDR:       next_read_data = pin_control_functions;
         `BIAS_AND_CONVERT_PIN_SELECT_ADDR: next_read_data = bias_and_convert_pin_select;
         default:                           next_read_data = `UNMAPPED_READ_VALUE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
         read_data <= `UNMAPPED_READ_VALUE;
      else
         read_data <= next_read_data;
   end

endmodule

/* logic/interface_pin_routing_cfg.sv */
`include "pin_routing_map.svh"

module interface_pin_routing_cfg
   import pin_routing_pkg::*;
(
   input  wire logic       CLOCK,
   input  wire logic       RESETN,
   input  wire logic       REG_WRITE,
   input  wire logic [7:0] REG_ADDRESS,
   input  wire logic [7:0] REG_WRITE_DATA,
   output logic      [7:0] REG_READ_DATA,
   input  wire logic       MULTI_PIN_ONE,
   input  wire logic       MULTI_PIN_TWO,
   input  wire logic       INPUT_ONLY_PIN,
   input  wire logic       SERIAL_IN_PIN,
   input  wire logic       SERIAL_OUT_PIN_IN,
   input  wire logic [3:0] SERIAL_OUT_FUNCTION,
   input  wire logic       PRIMARY_DATA_OUT,
   input  wire logic       SERIAL_OUT_ALT_DATA,
   input  wire logic       MIC_BIT_CLOCK,
   input  wire logic       RECORD_CONV_REG_POWERDOWN,
   input  wire logic       PLAYBACK_CONV_REG_POWERDOWN,
   output logic            AUX_PORT_IN_ONE,
   output logic            AUX_PORT_IN_TWO,
   output logic            PRIMARY_DATA_IN,
   output logic            REC_CH_ONE_DIGITAL,
   output logic            REC_CH_TWO_DIGITAL,
   output logic            MIC_CH_ONE_BIT,
   output logic            MIC_CH_TWO_BIT,
   output logic            MIC_CH_THREE_BIT,
   output logic            MIC_CH_FOUR_BIT,
   output logic            RECORD_CONV_POWERDOWN,
   output logic            PLAYBACK_CONV_POWERDOWN,
   output logic            POWER_LIMIT_CONTROL,
   output logic            AUX_FUNCTION_INPUT,
   output logic            MICROPHONE_BIAS_ENABLE,
   output logic            AUX_CONVERT_START,
   output logic            SERIAL_OUT_PIN_OUT,
   output logic            SERIAL_OUT_PIN_OE
);

   logic [7:0]      secondary_input_routing;
   logic [7:0]      microphone_input_config;
   logic [7:0]      pin_control_functions;
   logic [7:0]      bias_and_convert_pin_select;
   port_source_type aux_port_in_source;
   port_source_type aux_port_in_two_source;
   pin_source_type  mic_pair_a_source;
   pin_source_type  mic_pair_b_source;
   pin_source_type  record_conv_powerdown_pin;
   pin_source_type  playback_conv_powerdown_pin;
   pin_source_type  bias_enable_pin_select;
   pin_source_type  aux_convert_start_pin;
   logic            mic_source_override;
   logic            serial_out_with_in;
   logic            mic_pair_a_edge;
   logic            mic_pair_b_edge;
   logic            mic_only_pin;
   logic            serial_out_input;
   logic            primary_in;
   logic            mic_pair_a_data;
   logic            mic_pair_b_data;
   logic            mic_clock_last;
   logic            mic_rise;
   logic            mic_fall;
   logic            start_pin;
   logic            start_pin_last;
   logic            next_out;
   logic            next_oe;

   function automatic logic pick_pin(pin_source_type sel, logic one, logic two, logic only);
      logic result;
      result = 1'b0;
      unique case (sel)
         PIN_NONE:       result = 1'b0;
         PIN_MULTI_ONE:  result = one;
         PIN_MULTI_TWO:  result = two;
         PIN_INPUT_ONLY: result = only;
      endcase
      return result;
   endfunction

   function automatic logic pick_port(port_source_type sel, logic one, logic two, logic only,
                                      logic serial_out, logic primary);
      logic result;
      result = 1'b0;
      unique case (sel)
         PORT_NONE:        result = 1'b0;
         PORT_MULTI_ONE:   result = one;
         PORT_MULTI_TWO:   result = two;
         PORT_INPUT_ONLY:  result = only;
         PORT_SERIAL_OUT:  result = serial_out;
         PORT_PRIMARY_IN:  result = primary;
         PORT_SPARE_SIX:   result = 1'b0;
         PORT_SPARE_SEVEN: result = 1'b0;
      endcase
      return result;
   endfunction

   routing_register_bank bank
   (
      .clock                       (CLOCK),
      .resetn                      (RESETN),
      .write_enable                (REG_WRITE),
      .address                     (REG_ADDRESS),
      .write_data                  (REG_WRITE_DATA),
      .read_data                   (REG_READ_DATA),
      .secondary_input_routing     (secondary_input_routing),
      .microphone_input_config     (microphone_input_config),
      .pin_control_functions       (pin_control_functions),
      .bias_and_convert_pin_select (bias_and_convert_pin_select)
   );

   assign aux_port_in_source = port_source_type'(
      secondary_input_routing[`AUX_PORT_IN_SOURCE_MSB:`AUX_PORT_IN_SOURCE_LSB]);
   assign aux_port_in_two_source = port_source_type'(
      secondary_input_routing[`AUX_PORT_IN_TWO_SOURCE_MSB:`AUX_PORT_IN_TWO_SOURCE_LSB]);
   assign mic_pair_a_source = pin_source_type'(
      microphone_input_config[`MIC_PAIR_A_SOURCE_MSB:`MIC_PAIR_A_SOURCE_LSB]);
   assign mic_pair_b_source = pin_source_type'(
      microphone_input_config[`MIC_PAIR_B_SOURCE_MSB:`MIC_PAIR_B_SOURCE_LSB]);
   assign record_conv_powerdown_pin = pin_source_type'(
      pin_control_functions[`RECORD_CONV_POWERDOWN_PIN_MSB:`RECORD_CONV_POWERDOWN_PIN_LSB]);
   assign playback_conv_powerdown_pin = pin_source_type'(
      pin_control_functions[`PLAYBACK_CONV_POWERDOWN_PIN_MSB:`PLAYBACK_CONV_POWERDOWN_PIN_LSB]);
   assign bias_enable_pin_select = pin_source_type'(
      bias_and_convert_pin_select[`BIAS_ENABLE_PIN_SELECT_MSB:`BIAS_ENABLE_PIN_SELECT_LSB]);
   assign aux_convert_start_pin = pin_source_type'(
      bias_and_convert_pin_select[`AUX_CONVERT_START_PIN_MSB:`AUX_CONVERT_START_PIN_LSB]);
   assign mic_source_override = pin_control_functions[`MIC_SOURCE_OVERRIDE_BIT];
   assign serial_out_with_in  = pin_control_functions[`SERIAL_OUT_WITH_IN_BIT];
   assign mic_pair_a_edge     = microphone_input_config[`MIC_PAIR_A_EDGE_BIT];
   assign mic_pair_b_edge     = microphone_input_config[`MIC_PAIR_B_EDGE_BIT];

   // The serial out pin is only read back when it is configured to listen.
   assign serial_out_input = (serial_out_with_in || SERIAL_OUT_FUNCTION == `SERIAL_OUT_AS_INPUT)
                             ? SERIAL_OUT_PIN_IN : 1'b0;
   assign primary_in   = serial_out_with_in ? SERIAL_OUT_PIN_IN : SERIAL_IN_PIN;
   assign mic_only_pin = mic_source_override ? SERIAL_IN_PIN : INPUT_ONLY_PIN;

   assign mic_pair_a_data = pick_pin(mic_pair_a_source, MULTI_PIN_ONE, MULTI_PIN_TWO,
                                     mic_only_pin);
   assign mic_pair_b_data = pick_pin(mic_pair_b_source, MULTI_PIN_ONE, MULTI_PIN_TWO,
                                     mic_only_pin);
   assign mic_rise = MIC_BIT_CLOCK && !mic_clock_last;
   assign mic_fall = !MIC_BIT_CLOCK && mic_clock_last;
   assign start_pin = pick_pin(aux_convert_start_pin, MULTI_PIN_ONE, MULTI_PIN_TWO,
                               INPUT_ONLY_PIN);

   // Serial out pin drive; the shared mode keeps the primary data on the pin.
   always_comb
   begin
      next_out = 1'b0;
      next_oe  = 1'b0;
      if (serial_out_with_in)
      begin
         next_out = PRIMARY_DATA_OUT;
         next_oe  = 1'b1;
      end
      else
      begin
         unique case (SERIAL_OUT_FUNCTION)
            `SERIAL_OUT_DISABLED, `SERIAL_OUT_AS_INPUT, `SERIAL_OUT_RESERVED:
            begin
               next_out = 1'b0;
               next_oe  = 1'b0;
            end
            `SERIAL_OUT_PRIMARY_DATA:
            begin
               next_out = PRIMARY_DATA_OUT;
               next_oe  = 1'b1;
            end
            default:
            begin
               next_out = SERIAL_OUT_ALT_DATA;
               next_oe  = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RESETN)
      begin
         AUX_PORT_IN_ONE <= 1'b0;
         AUX_PORT_IN_TWO <= 1'b0;
         PRIMARY_DATA_IN <= 1'b0;
      end
      else
      begin
         AUX_PORT_IN_ONE <= pick_port(aux_port_in_source, MULTI_PIN_ONE, MULTI_PIN_TWO,
                                      INPUT_ONLY_PIN, serial_out_input, primary_in);
         AUX_PORT_IN_TWO <= pick_port(aux_port_in_two_source, MULTI_PIN_ONE, MULTI_PIN_TWO,
                                      INPUT_ONLY_PIN, serial_out_input, primary_in);
         PRIMARY_DATA_IN <= primary_in;
      end
   end

   assign REC_CH_ONE_DIGITAL = microphone_input_config[`REC_CH_ONE_TYPE_BIT];
   assign REC_CH_TWO_DIGITAL = microphone_input_config[`REC_CH_TWO_TYPE_BIT];

   // Microphone data is captured on both edges of the sampled bit clock; the edge bit picks which channel of each pair takes the rising one.
   always_ff @(posedge CLOCK)
   begin
      if (!RESETN)
      begin
         mic_clock_last   <= 1'b0;
         MIC_CH_ONE_BIT   <= 1'b0;
         MIC_CH_TWO_BIT   <= 1'b0;
         MIC_CH_THREE_BIT <= 1'b0;
         MIC_CH_FOUR_BIT  <= 1'b0;
      end
      else
      begin
         mic_clock_last <= MIC_BIT_CLOCK;
         if (mic_pair_a_edge ? mic_rise : mic_fall)
            MIC_CH_ONE_BIT <= mic_pair_a_data;
         if (mic_pair_a_edge ? mic_fall : mic_rise)
            MIC_CH_TWO_BIT <= mic_pair_a_data;
         if (mic_pair_b_edge ? mic_rise : mic_fall)
            MIC_CH_THREE_BIT <= mic_pair_b_data;
         if (mic_pair_b_edge ? mic_fall : mic_rise)
            MIC_CH_FOUR_BIT <= mic_pair_b_data;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RESETN)
      begin
         RECORD_CONV_POWERDOWN   <= 1'b0;
         PLAYBACK_CONV_POWERDOWN <= 1'b0;
         POWER_LIMIT_CONTROL     <= 1'b0;
         AUX_FUNCTION_INPUT      <= 1'b0;
         MICROPHONE_BIAS_ENABLE  <= 1'b0;
      end
      else
      begin
         RECORD_CONV_POWERDOWN <= RECORD_CONV_REG_POWERDOWN ||
            pick_pin(record_conv_powerdown_pin, MULTI_PIN_ONE, MULTI_PIN_TWO,
                     INPUT_ONLY_PIN);
         PLAYBACK_CONV_POWERDOWN <= PLAYBACK_CONV_REG_POWERDOWN ||
            pick_pin(playback_conv_powerdown_pin, MULTI_PIN_ONE, MULTI_PIN_TWO,
                     INPUT_ONLY_PIN);
         POWER_LIMIT_CONTROL <= pin_control_functions[`POWER_LIMIT_PIN_ENABLE_BIT]
                                && MULTI_PIN_ONE;
         AUX_FUNCTION_INPUT <= pin_control_functions[`AUX_FUNCTION_PIN_ENABLE_BIT]
                               && MULTI_PIN_ONE;
         MICROPHONE_BIAS_ENABLE <= pick_pin(bias_enable_pin_select, MULTI_PIN_ONE,
                                            MULTI_PIN_TWO, INPUT_ONLY_PIN);
      end
   end

   // A conversion start is a one-cycle pulse on the rising edge of the chosen pin.
   always_ff @(posedge CLOCK)
   begin
      if (!RESETN)
      begin
         start_pin_last    <= 1'b0;
         AUX_CONVERT_START <= 1'b0;
      end
      else
      begin
         start_pin_last    <= start_pin;
         AUX_CONVERT_START <= start_pin && !start_pin_last;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RESETN)
      begin
         SERIAL_OUT_PIN_OUT <= 1'b0;
         SERIAL_OUT_PIN_OE  <= 1'b0;
      end
      else
      begin
         SERIAL_OUT_PIN_OUT <= next_out;
         SERIAL_OUT_PIN_OE  <= next_oe;
      end
   end

   sequence s_pair_a_fall_normal;
      mic_fall && !mic_pair_a_edge && mic_pair_a_source == PIN_MULTI_ONE;
   endsequence

   sequence s_pair_b_rise_normal;
      mic_rise && !mic_pair_b_edge && mic_pair_b_source == PIN_MULTI_TWO;
   endsequence

   sequence s_start_rise;
      !start_pin ##1 start_pin;
   endsequence

   property p_aux_in_one;
      @(posedge CLOCK) disable iff (!RESETN)
      aux_port_in_source == PORT_MULTI_TWO |=> AUX_PORT_IN_ONE == $past(MULTI_PIN_TWO);
   endproperty
   a_aux_in_one: assert property (p_aux_in_one) else $error("aux input one mismatch");

   property p_aux_in_two;
      @(posedge CLOCK) disable iff (!RESETN)
      aux_port_in_two_source == PORT_PRIMARY_IN && !serial_out_with_in
      |=> AUX_PORT_IN_TWO == $past(SERIAL_IN_PIN);
   endproperty
   a_aux_in_two: assert property (p_aux_in_two) else $error("aux input two mismatch");

   property p_reserved_zero;
      @(posedge CLOCK) disable iff (!RESETN)
      REG_WRITE && REG_ADDRESS == `BIAS_AND_CONVERT_PIN_SELECT_ADDR
      |=> (bias_and_convert_pin_select & ~`BIAS_AND_CONVERT_PIN_SELECT_MASK) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   property p_ch_one_type;
      @(posedge CLOCK) disable iff (!RESETN)
      REG_WRITE && REG_ADDRESS == `MICROPHONE_INPUT_CONFIG_ADDR
      |=> REC_CH_ONE_DIGITAL == $past(REG_WRITE_DATA[`REC_CH_ONE_TYPE_BIT])
          && REC_CH_TWO_DIGITAL == $past(REG_WRITE_DATA[`REC_CH_TWO_TYPE_BIT]);
   endproperty
   a_ch_one_type: assert property (p_ch_one_type) else $error("type not applied");

   property p_pair_a_edge;
      @(posedge CLOCK) disable iff (!RESETN)
      s_pair_a_fall_normal |=> MIC_CH_ONE_BIT == $past(MULTI_PIN_ONE) && $stable(MIC_CH_TWO_BIT);
   endproperty
   a_pair_a_edge: assert property (p_pair_a_edge) else $error("pair a edge wrong");

   property p_pair_b_edge;
      @(posedge CLOCK) disable iff (!RESETN)
      s_pair_b_rise_normal |=> MIC_CH_FOUR_BIT == $past(MULTI_PIN_TWO)
                               && $stable(MIC_CH_THREE_BIT);
   endproperty
   a_pair_b_edge: assert property (p_pair_b_edge) else $error("pair b edge wrong");

   property p_override;
      @(posedge CLOCK) disable iff (!RESETN)
      mic_source_override && mic_pair_a_source == PIN_INPUT_ONLY && mic_fall && !mic_pair_a_edge
      |=> MIC_CH_ONE_BIT == $past(SERIAL_IN_PIN);
   endproperty
   a_override: assert property (p_override) else $error("override not applied");

   property p_record_pd;
      @(posedge CLOCK) disable iff (!RESETN)
      record_conv_powerdown_pin == PIN_INPUT_ONLY && INPUT_ONLY_PIN |=> RECORD_CONV_POWERDOWN;
   endproperty
   a_record_pd: assert property (p_record_pd) else $error("record power-down missed");

   property p_playback_pd;
      @(posedge CLOCK) disable iff (!RESETN)
      !PLAYBACK_CONV_REG_POWERDOWN && playback_conv_powerdown_pin == PIN_NONE
      |=> !PLAYBACK_CONV_POWERDOWN;
   endproperty
   a_playback_pd: assert property (p_playback_pd) else $error("stray power-down");

   property p_limit_aux;
      @(posedge CLOCK) disable iff (!RESETN)
      1'b1 |=> POWER_LIMIT_CONTROL
               == $past(pin_control_functions[`POWER_LIMIT_PIN_ENABLE_BIT] && MULTI_PIN_ONE)
               && AUX_FUNCTION_INPUT
               == $past(pin_control_functions[`AUX_FUNCTION_PIN_ENABLE_BIT] && MULTI_PIN_ONE);
   endproperty
   a_limit_aux: assert property (p_limit_aux) else $error("limit or aux pin wrong");

   property p_bias;
      @(posedge CLOCK) disable iff (!RESETN)
      bias_enable_pin_select == PIN_MULTI_TWO |=> MICROPHONE_BIAS_ENABLE == $past(MULTI_PIN_TWO);
   endproperty
   a_bias: assert property (p_bias) else $error("bias enable wrong");

   property p_start;
      @(posedge CLOCK) disable iff (!RESETN)
      s_start_rise |=> AUX_CONVERT_START ##1 !AUX_CONVERT_START;
   endproperty
   a_start: assert property (p_start) else $error("start pulse wrong");

   property p_serial_out;
      @(posedge CLOCK) disable iff (!RESETN)
      !serial_out_with_in && SERIAL_OUT_FUNCTION == `SERIAL_OUT_PRIMARY_DATA
      |=> SERIAL_OUT_PIN_OE && SERIAL_OUT_PIN_OUT == $past(PRIMARY_DATA_OUT);
   endproperty
   a_serial_out: assert property (p_serial_out) else $error("serial out not primary");

endmodule

/* tb/pin_partner.sv */
module pin_partner
(
   input  wire logic       clock,
   input  wire logic [5:0] pattern,
   output logic            pin_one,
   output logic            pin_two,
   output logic            pin_in_only,
   output logic            serial_in,
   output logic            serial_out_back,
   output logic            mic_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   // Board pins settle just after each edge, like real driven levels.
   always @(posedge clock)
   begin
      {pin_one, pin_two, pin_in_only, serial_in, serial_out_back, mic_clock} <= pattern;
   end
endmodule

/* tb/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, resetn = 0, reg_write = 0, pdo = 0, alt = 0, rpd = 0, ppd = 0, valid = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rd, e_rd, e_io, e_x;
   logic [3:0] sof = 4'h0;
   logic [5:0] pat = 6'h00;
   logic p1, p2, gi, si, soin, mck, a1, a2, pdi, t1, t2, rcpd, pbpd, power_limiter, afn, bias, sout;
   logic soe, sh, c1, c2, c3, c4, cst, est, ml, sl, rise, fall;
   logic [3:0] em;
   logic [7:0] r [18:21];
   logic [31:0] seed = 32'd82;
   int error_cnt = 0, checks_done = 0;
   always #2.5 clock = ~clock;
   pin_partner part (.clock(clock), .pattern(pat), .pin_one(p1), .pin_two(p2),
      .pin_in_only(gi), .serial_in(si), .serial_out_back(soin), .mic_clock(mck));
   interface_pin_routing_cfg uut (.CLOCK(clock), .RESETN(resetn), .REG_WRITE(reg_write),
      .REG_ADDRESS(addr), .REG_WRITE_DATA(wdata), .REG_READ_DATA(rd), .MULTI_PIN_ONE(p1),
      .MULTI_PIN_TWO(p2), .INPUT_ONLY_PIN(gi), .SERIAL_IN_PIN(si), .SERIAL_OUT_PIN_IN(soin),
      .SERIAL_OUT_FUNCTION(sof), .PRIMARY_DATA_OUT(pdo), .SERIAL_OUT_ALT_DATA(alt),
      .MIC_BIT_CLOCK(mck), .RECORD_CONV_REG_POWERDOWN(rpd), .PLAYBACK_CONV_REG_POWERDOWN(ppd),
      .AUX_PORT_IN_ONE(a1), .AUX_PORT_IN_TWO(a2), .PRIMARY_DATA_IN(pdi),
      .REC_CH_ONE_DIGITAL(t1), .REC_CH_TWO_DIGITAL(t2), .MIC_CH_ONE_BIT(c1),
      .MIC_CH_TWO_BIT(c2), .MIC_CH_THREE_BIT(c3), .MIC_CH_FOUR_BIT(c4),
      .RECORD_CONV_POWERDOWN(rcpd), .PLAYBACK_CONV_POWERDOWN(pbpd), .POWER_LIMIT_CONTROL(power_limiter),
      .AUX_FUNCTION_INPUT(afn), .MICROPHONE_BIAS_ENABLE(bias), .AUX_CONVERT_START(cst),
      .SERIAL_OUT_PIN_OUT(sout),
      .SERIAL_OUT_PIN_OE(soe));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function logic pick(input logic [1:0] s);
      return s == 2'd1 ? p1 : s == 2'd2 ? p2 : s == 2'd3 ? gi : 1'b0;
   endfunction
   // Microphone pin choice, with the serial in pin standing in for the input-only pin when r[20][7] is set.
   function logic pm(input logic [1:0] s);
      return s == 2'd3 ? (r[20][7] ? si : gi) : pick(s);
   endfunction
   function logic src(input logic [2:0] s);
      if (s == 3'd4)
         return (sof == 4'h1 || sh) ? soin : 1'b0;
      if (s == 3'd5)
         return sh ? soin : si;
      return s[2] ? 1'b0 : pick(s[1:0]);
   endfunction
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task stop_test;
      if (error_cnt == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Model works from the values held before each edge, then updates its registers.
   always @(posedge clock)
   begin
      sh = r[20][6];
      e_rd = (addr inside {[8'h12:8'h15]}) ? r[addr] : 8'h00;
      e_io = {src(r[18][7:5]), src(r[18][4:2]), sh ? soin : si, pick(r[20][5:4]) | rpd,
         pick(r[20][3:2]) | ppd, r[20][1] & p1, r[20][0] & p1, pick(r[21][7:6])};
      e_x[1] = sh || !(sof inside {4'h0, 4'h1, 4'hf});
      e_x[0] = e_x[1] & ((sh || sof == 4'h5) ? pdo : alt);
      if (!resetn)
         {em, ml, est, sl} = 7'h00;
      else
      begin
         rise = mck & !ml;
         fall = !mck & ml;
         if (r[19][5] ? rise : fall)
            em[3] = pm(r[19][3:2]);
         if (r[19][5] ? fall : rise)
            em[2] = pm(r[19][3:2]);
         if (r[19][4] ? rise : fall)
            em[1] = pm(r[19][1:0]);
         if (r[19][4] ? fall : rise)
            em[0] = pm(r[19][1:0]);
         ml = mck;
         est = pick(r[21][5:4]) & !sl;
         sl = pick(r[21][5:4]);
      end
      if (!resetn)
         r = '{8'h00, 8'h00, 8'h00, 8'h00};
      else if (reg_write && (addr inside {[8'h12:8'h15]}))
         r[addr] = wdata & (addr == 8'h12 ? 8'hfc : addr == 8'h15 ? 8'hf0 : 8'hff);
      valid <= resetn;
   end
   always @(negedge clock)
   begin
      if (valid)
      begin
         chk("read_data", e_rd, rd);
         chk("aux_in", {6'h00, e_io[7:6]}, {6'h00, a1, a2});
         chk("primary_in", {7'h00, e_io[5]}, {7'h00, pdi});
         chk("powerdown", {6'h00, e_io[4:3]}, {6'h00, rcpd, pbpd});
         chk("pin_func", {5'h00, e_io[2:0]}, {5'h00, power_limiter, afn, bias});
         chk("mic_bits", {4'h0, em}, {4'h0, c1, c2, c3, c4});
         chk("convert_start", {7'h00, est}, {7'h00, cst});
         chk("rec_type", {6'h00, r[19][7:6]}, {6'h00, t1, t2});
         chk("serial_out", {6'h00, e_x[1:0]}, {6'h00, soe, soe & sout});
      end
   end
   initial
   begin
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      repeat (6000)
      begin
         @(posedge clock);
         seed = xs(seed);
         resetn <= seed[31:22] != 10'h000;
         reg_write <= seed[0];
         addr <= 8'h10 + {5'h00, seed[3:1]};
         wdata <= seed[15:8] & (seed[3:1] == 3'd2 ? 8'hfc :
                                seed[3:1] == 3'd5 ? 8'hf0 : 8'hff);
         sof <= seed[19:16];
         {pdo, alt, rpd, ppd} <= seed[23:20];
         pat <= seed[29:24];
      end
      stop_test();
   end
endmodule
